// >>> hdl/external_memory_bus_unit.sv
// Bus control unit: clock, access timing and multiplexed external bus
`timescale 1ns/1ps
`default_nettype none
`include "ext_bus_defs.svh"
module external_memory_bus_unit
  import ext_bus_pkg::*;
(
  // Clock and reset
  input  wire logic            i_core_clk,
  input  wire logic            i_rst,
  // Configuration
  input  wire logic [2:0]      i_external_memory_size_setting,
  input  wire logic [7:0]      i_wait_control_internal,
  input  wire logic [7:0]      i_wait_control_external,
  input  wire logic            i_address_wait_select_low,
  input  wire logic            i_address_wait_select_high,
  // Processor request and answer
  input  wire bus_request_type i_req,
  output logic                 o_req_ready,
  output bus_answer_type       o_ans,
  output logic [2:0]           o_queue_limit,
  output logic                 o_int_read,
  // Internal memory data
  input  wire logic [7:0]      i_int_rdata,
  // General-purpose port control
  input  wire port_ctrl_type   i_low_port_ctrl,
  input  wire port_ctrl_type   i_high_port_ctrl,
  output logic [7:0]           o_low_port_in,
  output logic [7:0]           o_high_port_in,
  // External bus pins
  input  wire logic [7:0]      i_muxed_low_address_data,
  output logic [7:0]           o_muxed_low_address_data,
  output logic [7:0]           o_muxed_low_address_data_oe,
  input  wire logic [7:0]      i_high_address_lines,
  output logic [7:0]           o_high_address_lines,
  output logic [7:0]           o_high_address_lines_oe,
  output logic                 o_address_latch_strobe,
  output logic                 o_read_strobe_n,
  output logic                 o_store_strobe_n,
  input  wire logic            i_wait_n,
  output logic                 o_system_clock_output
);
  // ------------------------------------------------------------
  // Clock
  // ------------------------------------------------------------
  logic sys_tick;

  sys_clock_divider u_div (
    .i_core_clk            (i_core_clk),
    .i_rst                 (i_rst),
    .o_sys_tick            (sys_tick),
    .o_system_clock_output (o_system_clock_output)
  );

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    st_idle,
    st_internal,
    st_addr,
    st_data,
    st_done
  } bus_state_type;

  bus_state_type state_reg;
  bus_state_type state_next;
  logic [15:0]   ext_top;
  logic          in_main;
  logic          in_periph;
  logic          in_ext;
  logic [7:0]    high_owned;
  logic [15:0]   a;

  assign a = i_req.addr;
  assign in_main   = (a >= `MAIN_RAM_LO) && (a <= `MAIN_RAM_HI);
  assign in_periph = (a >= `PERIPH_RAM_LO) && (a <= `PERIPH_RAM_HI);

  // External window grows up from the area base
  always_comb begin
    case (i_external_memory_size_setting)
      `SIZE_256: ext_top = `EXT_AREA_LO + 16'h00FF;
      `SIZE_4K:  ext_top = `EXT_AREA_LO + 16'h0FFF;
      `SIZE_16K: ext_top = `EXT_AREA_LO + 16'h3FFF;
      `SIZE_32K: ext_top = `EXT_AREA_HI;
      default:   ext_top = 16'h0000;
    endcase
  end

  assign in_ext = (i_external_memory_size_setting != `SIZE_NONE)
               && (a >= `EXT_AREA_LO) && (a <= ext_top)
               && !in_main && !in_periph;

  always_comb begin
    case (i_external_memory_size_setting)
      `SIZE_4K:  high_owned = 8'h0F;
      `SIZE_16K: high_owned = 8'h3F;
      `SIZE_32K: high_owned = 8'hFF;
      default:   high_owned = 8'h00;
    endcase
  end

  // ------------------------------------------------------------
  // Access timing
  // ------------------------------------------------------------
  logic [1:0]  base_clks;
  logic [1:0]  prog_waits;
  logic [7:0]  wait_field;
  logic        aw_sel;
  logic        ext_cycle;
  logic [2:0]  count_reg;
  logic [2:0]  count_next;
  logic [2:0]  aw_reg;
  logic        is_ext_reg;
  bus_request_type req_reg;

  assign ext_cycle = in_ext || in_periph;
  assign wait_field = in_ext ? i_wait_control_external
                             : i_wait_control_internal;
  // Two bits per 16K block select extra waits
  assign prog_waits = wait_field[{a[15:14], 1'b0} +: 2];
  assign aw_sel = a[15] ? i_address_wait_select_high
                        : i_address_wait_select_low;

  always_comb begin
    if (in_main && (i_req.mode != acc_memory))
      base_clks = `MAIN_FAST_SYSCLK;
    else if (in_main)
      base_clks = `MAIN_MEM_SYSCLK;
    else if (ext_cycle)
      base_clks = `EXT_BASE_SYSCLK;
    else
      base_clks = `PROG_FETCH_SYSCLK;
  end

  // Prefetch depth depends on where code lives
  assign o_queue_limit = in_ext ? `EXT_QUEUE_MAX : `INT_QUEUE_MAX;

  // Peripheral RAM runs the bus sequence at external pace but stays
  // on chip, so its reads count as internal reads
  logic busy_phase;

  assign busy_phase  = (state_reg == st_internal)
                    || (state_reg == st_addr)
                    || (state_reg == st_data);
  assign o_req_ready = (state_reg == st_idle);
  assign o_int_read  = busy_phase && !is_ext_reg && !req_reg.write;

  // ------------------------------------------------------------
  // Sequencer, stepped on system clock ticks
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    case (state_reg)
      st_idle: begin
        if (i_req.valid) begin
          state_next = ext_cycle ? st_addr : st_internal;
          // Main RAM waits do not apply; they are not slow memory
          count_next = 3'(base_clks)
                     + (in_main ? 3'h0 : 3'(prog_waits)) - 3'h1;
        end
      end
      st_internal: begin
        if (count_reg == 3'h0)
          state_next = st_done;
        else
          count_next = count_reg - 3'h1;
      end
      st_addr: begin
        // Address phase lasts one clock, two with address wait
        if (aw_reg == 3'h0) begin
          state_next = st_data;
          count_next = count_reg - 3'h1;
        end
      end
      st_data: begin
        if (count_reg == 3'h0) begin
          // Only a true external cycle listens to the wait pin
          if (i_wait_n || !is_ext_reg)
            state_next = st_done;
        end else begin
          count_next = count_reg - 3'h1;
        end
      end
      st_done: state_next = st_idle;
      default: state_next = st_idle;
    endcase
  end

  // ------------------------------------------------------------
  // Read data source
  // ------------------------------------------------------------
  logic [7:0] cap_data;

  // Pins for true external cycles, internal array for everything else
  assign cap_data = is_ext_reg ? i_muxed_low_address_data : i_int_rdata;

  logic [7:0] rdata_reg;
  logic       done_reg;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_reg  <= st_idle;
      count_reg  <= 3'h0;
      aw_reg     <= 3'h0;
      is_ext_reg <= 1'b0;
      req_reg    <= '0;
      rdata_reg  <= 8'h00;
      done_reg   <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (sys_tick) begin
        state_reg <= state_next;
        count_reg <= count_next;
        if (state_reg == st_idle && i_req.valid) begin
          req_reg    <= i_req;
          // Peripheral RAM is on chip: no strobes or low-line drive, but its high address byte still shows on the high lines that the size setting gives to the bus
          is_ext_reg <= in_ext;
          aw_reg     <= aw_sel ? 3'h1 : 3'h0;
        end else if (state_reg == st_addr && aw_reg != 3'h0) begin
          aw_reg <= aw_reg - 3'h1;
        end
        if (state_next == st_done)
          rdata_reg <= cap_data;
        done_reg <= (state_next == st_done);
      end
    end
  end

  assign o_ans.done     = done_reg;
  assign o_ans.rdata    = rdata_reg;
  assign o_ans.external = is_ext_reg;

  // ------------------------------------------------------------
  // Pins
  // ------------------------------------------------------------
  logic       addr_phase;
  logic       data_phase;
  logic       bus_busy;
  logic [7:0] low_bus_out;
  logic [7:0] low_bus_oe;
  logic [7:0] low_dir;

  // Peripheral RAM cycles keep the strobes quiet on the pins
  assign addr_phase = (state_reg == st_addr) && is_ext_reg;
  assign data_phase = (state_reg == st_data) && is_ext_reg;
  assign bus_busy   = (i_external_memory_size_setting != `SIZE_NONE);

  assign o_address_latch_strobe = addr_phase;
  assign o_read_strobe_n  = !(data_phase && !req_reg.write);
  assign o_store_strobe_n = !(data_phase && req_reg.write);

  // Address then data on the shared lines; released for reads
  assign low_bus_out = addr_phase ? req_reg.addr[7:0]
                                  : req_reg.wdata;
  assign low_bus_oe  = {8{addr_phase || (data_phase && req_reg.write)}};
  assign low_dir     = {8{i_low_port_ctrl.dir_out[0]}};

  io_port_mux #(.WIDTH(8)) u_low (
    .i_bus_owned (8'(0) | {8{bus_busy}}),
    .i_bus_out   (low_bus_out),
    .i_bus_oe    (low_bus_oe),
    .i_gpio_out  (i_low_port_ctrl.out_data),
    .i_gpio_dir  (low_dir),
    .o_pin       (o_muxed_low_address_data),
    .o_pin_oe    (o_muxed_low_address_data_oe)
  );

  io_port_mux #(.WIDTH(8)) u_high (
    .i_bus_owned (high_owned),
    .i_bus_out   (req_reg.addr[15:8]),
    .i_bus_oe    (high_owned),
    .i_gpio_out  (i_high_port_ctrl.out_data),
    .i_gpio_dir  (i_high_port_ctrl.dir_out),
    .o_pin       (o_high_address_lines),
    .o_pin_oe    (o_high_address_lines_oe)
  );

  assign o_low_port_in  = i_muxed_low_address_data;
  assign o_high_port_in = i_high_address_lines;
endmodule
`default_nettype wire

// >>> hdl/ext_bus_defs.svh
// Constants for the external memory bus unit
`ifndef EXT_BUS_DEFS_SVH
`define EXT_BUS_DEFS_SVH
`define CLK_DIV_RATIO        2
`define MAIN_RAM_LO          16'hFE00
`define MAIN_RAM_HI          16'hFE7F
`define PERIPH_RAM_LO        16'hFC80
`define PERIPH_RAM_HI        16'hFD7F
`define EXT_AREA_LO          16'h8000
`define EXT_AREA_HI          16'hFDFE
`define MAIN_FAST_SYSCLK     2'h1
`define MAIN_MEM_SYSCLK      2'h2
`define PROG_FETCH_SYSCLK    2'h2
`define EXT_BASE_SYSCLK      2'h3
`define EXT_QUEUE_MAX        3'h3
`define INT_QUEUE_MAX        3'h5
`define SIZE_NONE            3'h0
`define SIZE_256             3'h1
`define SIZE_4K              3'h2
`define SIZE_16K             3'h3
`define SIZE_32K             3'h4
`endif

// >>> hdl/ext_bus_pkg.sv
// Types shared by the external memory bus unit
package ext_bus_pkg;
  typedef enum logic [1:0] {
    acc_register,
    acc_short,
    acc_memory,
    acc_fetch
  } access_mode_type;

  typedef struct packed {
    logic            valid;
    logic            write;
    access_mode_type mode;
    logic [15:0]     addr;
    logic [7:0]      wdata;
  } bus_request_type;

  typedef struct packed {
    logic       done;
    logic [7:0] rdata;
    logic       external;
  } bus_answer_type;

  typedef struct packed {
    logic [7:0] out_data;
    logic [7:0] dir_out;
  } port_ctrl_type;
endpackage

// >>> hdl/sys_clock_divider.sv
// Halves the oscillator into a system clock enable and clock output
`timescale 1ns/1ps
`default_nettype none
`include "ext_bus_defs.svh"
module sys_clock_divider (
  // Clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_rst,
  // System clock
  output logic      o_sys_tick,
  output logic      o_system_clock_output
);
  logic phase_reg;
  logic clk_out_reg;

  // Tick once every two oscillator periods
  assign o_sys_tick            = phase_reg;
  assign o_system_clock_output = clk_out_reg;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      phase_reg   <= 1'b0;
      clk_out_reg <= 1'b0;
    end else begin
      phase_reg   <= ~phase_reg;
      clk_out_reg <= ~phase_reg;
    end
  end
endmodule
`default_nettype wire

// >>> hdl/io_port_mux.sv
// One port pin group: bus function or general-purpose I/O per bit
`timescale 1ns/1ps
`default_nettype none
module io_port_mux #(
  parameter int WIDTH = 8
) (
  // Selection
  input  wire logic [WIDTH-1:0] i_bus_owned,
  input  wire logic [WIDTH-1:0] i_bus_out,
  input  wire logic [WIDTH-1:0] i_bus_oe,
  // General-purpose side
  input  wire logic [WIDTH-1:0] i_gpio_out,
  input  wire logic [WIDTH-1:0] i_gpio_dir,
  // Pin side
  output logic      [WIDTH-1:0] o_pin,
  output logic      [WIDTH-1:0] o_pin_oe
);
  // Refuse a port group with no pins before anything is built
  if (WIDTH < 1) begin : g_width_check
    $error("io_port_mux width must be positive");
  end

  assign o_pin    = (i_bus_owned & i_bus_out) | (~i_bus_owned & i_gpio_out);
  assign o_pin_oe = (i_bus_owned & i_bus_oe) | (~i_bus_owned & i_gpio_dir);
endmodule
`default_nettype wire

// >>> dv/ext_bus_chk_sva.sv
// Assertion checker for the external memory bus unit
`timescale 1ns/1ps
`default_nettype none
module ext_bus_chk
  import ext_bus_pkg::*;
(
  input wire logic           i_core_clk,
  input wire logic           i_rst,
  input wire logic [2:0]     i_external_memory_size_setting,
  input wire port_ctrl_type  i_high_port_ctrl,
  input wire bus_answer_type o_ans,
  input wire logic [7:0]     o_muxed_low_address_data_oe,
  input wire logic [7:0]     o_high_address_lines_oe,
  input wire logic           o_address_latch_strobe,
  input wire logic           o_read_strobe_n,
  input wire logic           o_store_strobe_n,
  input wire logic           i_wait_n,
  input wire logic           o_system_clock_output
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  wire logic [7:0] oe = o_muxed_low_address_data_oe;
  wire logic       ale = o_address_latch_strobe;
  wire logic       rd = !o_read_strobe_n;
  wire logic       st = !o_store_strobe_n;
  a_clock_toggles: assert property (
    !$past(i_rst) && !$past(i_rst, 2) |->
    o_system_clock_output != $past(o_system_clock_output))
    else $error("clock output stuck");
  a_strobe_width: assert property (
    $rose(ale) |=> ale) else $error("short latch strobe");
  a_one_strobe: assert property (
    !(rd && st) && !(ale && (rd || st))) else $error("strobes overlap");
  a_read_release: assert property (
    rd |-> oe == 8'h00) else $error("read phase drives bus");
  a_store_drive: assert property (
    st |-> oe == 8'hFF) else $error("store phase undriven");
  a_wait_hold: assert property (
    rd && !i_wait_n |=> rd) else $error("wait ignored");
  a_done_pulse: assert property (
    o_ans.done |=> !o_ans.done) else $error("done too long");
  a_gpio_high: assert property (
    i_external_memory_size_setting <= 3'h1 |->
    o_high_address_lines_oe == i_high_port_ctrl.dir_out)
    else $error("high port not general purpose");
  c_read: cover property ($fell(o_read_strobe_n));
  c_store: cover property ($fell(o_store_strobe_n));
  c_wait: cover property (rd && !i_wait_n);
endmodule
bind external_memory_bus_unit ext_bus_chk ext_bus_chk_i (
  .i_core_clk, .i_rst, .i_external_memory_size_setting, .i_high_port_ctrl,
  .o_ans, .o_muxed_low_address_data_oe, .o_high_address_lines_oe,
  .o_address_latch_strobe, .o_read_strobe_n, .o_store_strobe_n, .i_wait_n,
  .o_system_clock_output);
`default_nettype wire

// >>> dv/ext_mem_model.sv
// Behavioural external memory: address latch, read data and wait
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
  input  wire logic       i_core_clk,
  input  wire logic       i_ale,
  input  wire logic       i_rd_n,
  input  wire logic       i_st_n,
  input  wire logic [7:0] i_lo,
  input  wire logic [7:0] i_hi,
  input  wire logic [3:0] i_wait_clks,
  output logic      [7:0] o_lo,
  output logic            o_wait_n,
  output logic     [15:0] o_addr,
  output logic      [7:0] o_wdata
);
  logic [3:0] cnt_reg;
  logic [7:0] last_reg;
  always_ff @(posedge i_core_clk) begin
    if (i_ale) o_addr <= {i_hi, i_lo};
    if (!i_st_n) o_wdata <= i_lo;
    cnt_reg <= i_rd_n ? 4'h0 : cnt_reg + 4'h1;
    last_reg <= i_lo;
  end
  // Released lines show a moving pattern so a stale value never passes
  assign o_lo = i_rd_n ? ~last_reg : o_addr[15:8] ^ o_addr[7:0];
  assign o_wait_n = i_rd_n || cnt_reg >= i_wait_clks;
endmodule
`default_nettype wire

// >>> dv/test_external_memory_bus_unit.sv
// Self-checking bench for the external memory bus unit
`timescale 1ns/1ps
`default_nettype none
module test_external_memory_bus_unit import ext_bus_pkg::*;;
  logic            clk = 0, rst = 1, aw_hi = 0, ext;
  logic [2:0]      sz = 3'h4;
  logic [7:0]      wci = 8'h00, hi_ext = 8'h5A, rdat;
  logic [3:0]      wclks = 4'h0;
  bus_request_type req = '0;
  port_ctrl_type   lpc = '0, hpc = '0;
  bus_answer_type  ans;
  logic            ready, ale, rd_n, st_n, wait_n, clk_out;
  logic [7:0]      lo_out, lo_oe, hi_out, hi_oe, hi_in, mdl_lo, wdata;
  logic [15:0]     maddr, ale_c, rd_c, st_c, ir_c, n, cyc = 0;
  logic [15:0]     ale_t = 0, rd_t = 0, st_t = 0, ir_t = 0;
  logic [7:0]      wce = 8'h00, lo_in;
  logic [2:0]      qlim;
  logic            int_rd;
  int              bad_count = 0, samples_checked = 0;
  wire logic [7:0] lo_bus = (lo_oe & lo_out) | (~lo_oe & mdl_lo);
  wire logic [7:0] hi_bus = (hi_oe & hi_out) | (~hi_oe & hi_ext);
  external_memory_bus_unit external_memory_bus_unit_i (
    .i_core_clk(clk), .i_rst(rst), .i_external_memory_size_setting(sz),
    .i_wait_control_internal(wci), .i_wait_control_external(wce),
    .i_address_wait_select_low(1'b0), .i_address_wait_select_high(aw_hi),
    .i_req(req), .o_req_ready(ready), .o_ans(ans), .o_queue_limit(qlim),
    .o_int_read(int_rd), .i_int_rdata(8'h3C), .i_low_port_ctrl(lpc),
    .i_high_port_ctrl(hpc), .o_low_port_in(lo_in), .o_high_port_in(hi_in),
    .i_muxed_low_address_data(lo_bus), .o_muxed_low_address_data(lo_out),
    .o_muxed_low_address_data_oe(lo_oe), .i_high_address_lines(hi_bus),
    .o_high_address_lines(hi_out), .o_high_address_lines_oe(hi_oe),
    .o_address_latch_strobe(ale), .o_read_strobe_n(rd_n),
    .o_store_strobe_n(st_n), .i_wait_n(wait_n),
    .o_system_clock_output(clk_out));
  ext_mem_model ext_mem_model_i (.i_core_clk(clk), .i_ale(ale),
    .i_rd_n(rd_n), .i_st_n(st_n), .i_lo(lo_bus), .i_hi(hi_bus),
    .i_wait_clks(wclks), .o_lo(mdl_lo), .o_wait_n(wait_n),
    .o_addr(maddr), .o_wdata(wdata));
  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 16'h1;
    ale_t <= ale_t + 16'(ale);
    rd_t <= rd_t + 16'(!rd_n);
    st_t <= st_t + 16'(!st_n);
    ir_t <= ir_t + 16'(int_rd);
    if (cyc == 16'd5000) begin
      bad_count++;
      complete_run();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Requests start in a fixed clock-output phase so latencies compare
  task automatic acc(input logic w, input access_mode_type m,
                     input logic [15:0] a, input logic [7:0] d);
    logic [15:0] a0, r0, s0, i0;
    @(posedge clk);
    #1;
    while (clk_out !== 1'b1 || ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    req = '{1'b1, w, m, a, d};
    {a0, r0, s0, i0} = {ale_t, rd_t, st_t, ir_t};
    n = 16'h0;
    do begin
      @(posedge clk);
      #1;
      n++;
      if (ready !== 1'b1 || ans.done === 1'b1) req.valid = 1'b0;
    end while (ans.done !== 1'b1 && n < 16'd300);
    ale_c = ale_t - a0;
    rd_c = rd_t - r0;
    st_c = st_t - s0;
    ir_c = ir_t - i0;
    chk("done", 16'h1, 16'(ans.done));
    rdat = ans.rdata;
    ext = ans.external;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_internal;
    logic [15:0] base;
    acc(0, acc_short, 16'hFE10, 0);
    base = n;
    chk("internal data", 16'h3C, 16'(rdat));
    chk("internal read clocks", 16'h2, ir_c);
    acc(0, acc_register, 16'hFE10, 0);
    chk("register clocks", base, n);
    acc(0, acc_memory, 16'hFE10, 0);
    chk("memory clocks", base + 16'h2, n);
    acc(0, acc_fetch, 16'h0100, 0);
    chk("fetch clocks", base + 16'h2, n);
    chk("internal queue", 16'h5, 16'(qlim));
    acc(0, acc_memory, 16'hFC80, 0);
    chk("peripheral clocks", base + 16'h4, n);
    chk("peripheral strobes", 16'h0, rd_c);
    wci = 8'h40;
    acc(0, acc_memory, 16'hFC80, 0);
    chk("waited clocks", base + 16'h6, n);
    wci = 8'h00;
    acc(0, acc_memory, 16'h7FFF, 0);
    chk("below window", 16'h0, 16'(ext));
    $display("internal test done");
  endtask
  task automatic t_ext;
    acc(0, acc_memory, 16'h9234, 0);
    chk("read data", 16'hA6, 16'(rdat));
    chk("external flag", 16'h1, 16'(ext));
    chk("latched address", 16'h9234, maddr);
    chk("strobe clocks", 16'h2, ale_c);
    chk("read clocks", 16'h4, rd_c);
    chk("no internal read", 16'h0, ir_c);
    acc(0, acc_fetch, 16'hFDFE, 0);
    chk("top read data", 16'h03, 16'(rdat));
    chk("fetch clocks", 16'h4, rd_c);
    chk("external queue", 16'h3, 16'(qlim));
    acc(1, acc_memory, 16'h8155, 8'hA5);
    chk("store data", 16'hA5, 16'(wdata));
    chk("store clocks", 16'h4, st_c);
    wclks = 4'h4;
    acc(0, acc_memory, 16'h9234, 0);
    chk("wait clocks", 16'h6, rd_c);
    wclks = 4'h0;
    aw_hi = 1;
    acc(0, acc_memory, 16'h9234, 0);
    chk("wide strobe", 16'h4, ale_c);
    aw_hi = 0;
    wce = 8'h10;
    acc(0, acc_memory, 16'h9234, 0);
    chk("external waits", 16'h6, rd_c);
    wce = 8'h00;
    $display("external test done");
  endtask
  task automatic t_ports;
    sz = 3'h0;
    hpc = '{8'h3C, 8'hA5};
    lpc = '{8'h96, 8'h01};
    @(posedge clk);
    #1;
    chk("high port enable", 16'hA5, 16'(hi_oe));
    chk("high port pins", 16'h7E, 16'(hi_in));
    chk("low port enable", 16'hFF, 16'(lo_oe));
    chk("low port data", 16'h96, 16'(lo_out));
    chk("low port pins", 16'h96, 16'(lo_in));
    sz = 3'h2;
    @(posedge clk);
    #1;
    chk("shared high port", 16'hA, 16'(hi_oe[7:4]));
    $display("port test done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    #1;
    rst = 0;
    t_internal;
    t_ext;
    t_ports;
    complete_run();
  end
endmodule
`default_nettype wire
